// ==== bench/counter_array_checker.sv ====
`timescale 1ns/1ps
module counter_array_checker (
    input logic        clock,
    input logic        reset_n,
    input logic [7:0]  sfr_addr,
    input logic [7:0]  sfr_wdata,
    input logic        sfr_write,
    input logic        sfr_read,
    input logic [7:0]  sfr_rdata,
    input logic [5:0]  module_event,
    input logic [5:0]  module_irq_enable,
    input logic        counter_array_irq,
    input logic        watchdog_reset,
    input logic [15:0] counter_value,
    input logic        counter_tick,
    input logic        watchdog_active
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    sequence s_evt;
        |(module_event & module_irq_enable) && !sfr_write
        ##1 $stable(module_irq_enable) && !sfr_write;
    endsequence
    sequence s_kick;
        sfr_write && sfr_addr == 8'hD8 && sfr_wdata[5] && watchdog_active;
    endsequence
    AST_EVT_IRQ: assert property (s_evt |=> counter_array_irq)
        else $error("event irq missing");
    AST_KICK: assert property (s_kick |=> watchdog_reset)
        else $error("forced reset missing");
    AST_KICK_ONE: assert property (watchdog_reset |=> !watchdog_reset)
        else $error("reset pulse too long");
    AST_STEP: assert property (counter_tick |=>
        counter_value == $past(counter_value) + 16'h1)
        else $error("counter did not step by one");
    AST_HOLD: assert property (!counter_tick |=> $stable(counter_value))
        else $error("counter moved without tick");
    AST_BIT4: assert property (sfr_read && sfr_addr == 8'hD9 |=>
        !sfr_rdata[4])
        else $error("mode bit 4 read as one");
    AST_WD_ON: assert property (sfr_write && sfr_addr == 8'hD9 &&
        |sfr_wdata[6:5] |=> ##1 watchdog_active)
        else $error("watchdog not enabled");
    AST_WD_OFF: assert property ($fell(watchdog_active) |->
        $past(sfr_write && sfr_addr == 8'hD9 && sfr_wdata[6:5] == 2'h0, 2))
        else $error("watchdog dropped without a clearing write");
endmodule : counter_array_checker
bind counter_array_control_mode counter_array_checker counter_array_checker_i (.*);

// ==== bench/cpu_model.sv ====
`timescale 1ns/1ps
// One access at a time, launched on the falling edge and held across
// the rising edge that takes it.
module cpu_model (
    input  logic       clock,
    output logic [7:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    output logic       sfr_write,
    output logic       sfr_read,
    input  logic [7:0] sfr_rdata
);
    initial {sfr_addr, sfr_wdata, sfr_write, sfr_read} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        {sfr_addr, sfr_wdata, sfr_write} = {a, d, 1'b1};
        @(negedge clock);
        {sfr_wdata, sfr_write} = {~d, 1'b0};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        {sfr_addr, sfr_read} = {a, 1'b1};
        @(negedge clock);
        sfr_read = 1'b0;
        d = sfr_rdata;
    endtask : rd
endmodule : cpu_model

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    localparam int WIN = 96;
    logic        clock, reset_n, sfr_write, sfr_read, cpu_idle;
    logic        timer0_overflow, timer4_overflow, timer5_overflow;
    logic        external_count_input, ext_osc, counter_array_irq;
    logic        watchdog_reset, counter_tick, watchdog_active;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rd, ev;
    logic [5:0]  module_event, module_irq_enable;
    logic [15:0] counter_value;
    logic [31:0] lfsr;
    int          err_count, checks_done, n, p, w;
    counter_array_control_mode counter_array_control_mode_i (.*);
    cpu_model cpu_model_i (.*);
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic int ticks_for(input int s, input int pulses);
        case (s)
            0: return WIN / 12;
            1: return WIN / 4;
            4: return WIN;
            5: return WIN / 16;
            default: return pulses;
        endcase
    endfunction : ticks_for
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    // Prescaler phase and synchroniser delay allow one tick either way.
    task automatic check_near(input int e);
        check(16'(((n - e) inside {[-1:1]}) ? e : n), 16'(e));
    endtask : check_near
    task automatic count_ticks(input int cycles);
        n = 0;
        repeat (cycles) begin
            @(negedge clock);
            n += counter_tick;
        end
    endtask : count_ticks
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        {reset_n, cpu_idle, ext_osc, module_event, module_irq_enable} = '0;
        {timer0_overflow, timer4_overflow, timer5_overflow} = '0;
        external_count_input = 1'b1;
        {err_count, checks_done} = '0;
        lfsr = 32'hBEF9289C;
        repeat (12) @(negedge clock);
        reset_n = 1'b1;
        cpu_model_i.rd(8'hD8, rd);
        check(rd, 8'h00);
        cpu_model_i.rd(8'hD9, rd);
        check(rd, 8'h40);
        cpu_model_i.rd(8'hDA, rd);
        check(rd, 8'h00);
        check(watchdog_active, 1'b1);
        count_ticks(40);
        check(n != 0, 1'b1);
        cpu_model_i.wr(8'hD9, 8'hDF);
        cpu_model_i.rd(8'hD9, rd);
        check(rd, 8'h40);
        cpu_model_i.wr(8'hD8, 8'h20);
        check(watchdog_reset, 1'b1);
        cpu_model_i.wr(8'hD9, 8'h10);
        cpu_model_i.rd(8'hD9, rd);
        check(rd, 8'h00);
        check(watchdog_active, 1'b0);
        $display("watchdog test done");
        for (int s = 0; s < 8; s++) begin
            cpu_model_i.wr(8'hD9, {4'h0, 3'(s), 1'b0});
            cpu_model_i.wr(8'hD8, 8'h40);
            p = 0;
            n = 0;
            for (int c = 0; c < WIN; c++) begin
                @(negedge clock);
                lfsr = lfsr_next(lfsr);
                cpu_idle = lfsr[3];
                {timer0_overflow, timer4_overflow, timer5_overflow} =
                    (c < WIN - 8) ? lfsr[2:0] : 3'h0;
                external_count_input = (c < WIN - 8) ? ~c[2] : 1'b1;
                ext_osc = s == 5 && !ext_osc;
                ev = {timer5_overflow, timer4_overflow, 2'h0,
                      c % 8 == 4 && c < WIN - 8, timer0_overflow, 2'h0};
                p += ev[s];
                n += counter_tick;
            end
            check_near(ticks_for(s, p));
        end
        cpu_model_i.wr(8'hD8, 8'h00);
        count_ticks(20);
        check(16'(n), 16'h0000);
        cpu_idle = 1'b1;
        cpu_model_i.wr(8'hD9, 8'h88);
        cpu_model_i.wr(8'hD8, 8'h40);
        count_ticks(20);
        check(16'(n), 16'h0000);
        cpu_idle = 1'b0;
        count_ticks(20);
        check_near(20);
        $display("timebase test done");
        for (int k = 0; k < 6; k++) begin
            cpu_model_i.wr(8'hD8, 8'h40);
            module_irq_enable = 6'h00;
            @(negedge clock) module_event = 6'h01 << k;
            @(negedge clock) module_event = 6'h00;
            repeat (2) @(negedge clock);
            check(counter_array_irq, 1'b0);
            cpu_model_i.rd(8'hD8, rd);
            check(rd[5:0], 6'h01 << k);
            module_irq_enable = 6'h01 << k;
            repeat (2) @(negedge clock);
            check(counter_array_irq, 1'b1);
        end
        @(negedge clock) module_event = 6'h20;
        @(negedge clock) module_event = 6'h00;
        @(negedge clock);
        check(counter_array_irq, 1'b1);
        module_irq_enable = 6'h00;
        $display("event test done");
        cpu_model_i.wr(8'hD9, 8'h08);
        cpu_model_i.wr(8'hD8, 8'h40);
        for (w = 0; w < 70000 && counter_value !== 16'hFFFF; w++)
            @(negedge clock);
        if (w < 70000) begin
            repeat (4) @(negedge clock);
            check(counter_array_irq, 1'b0);
            cpu_model_i.rd(8'hD8, rd);
            check(rd[7], 1'b1);
            cpu_model_i.wr(8'hD9, 8'h09);
            repeat (2) @(negedge clock);
            check(counter_array_irq, 1'b1);
            cpu_model_i.wr(8'hD8, 8'h40);
            repeat (2) @(negedge clock);
            check(counter_array_irq, 1'b0);
        end else
            err_count++;
        cpu_model_i.wr(8'hD9, 8'h20);
        cpu_model_i.wr(8'hD9, 8'h00);
        cpu_model_i.rd(8'hD9, rd);
        check(rd, 8'h60);
        check(watchdog_active, 1'b1);
        $display("overflow and lock test done");
        tally_and_finish();
    end
endmodule : tb_top

// ==== rtl/counter_array_control_mode.sv ====
`timescale 1ns/1ps
`include "counter_array_defines.svh"

// What this block does
// R1 - The overflow flag sets when the counter wraps 0xFFFF to 0x0000 and only software clears it.
// R2 - With the overflow interrupt enable at 1 a set overflow flag requests the interrupt, at 0 it does not.
// R3 - The run control bit starts the counter at 1 and, with the watchdog disabled, stops it at 0.
// R4 - Each of six module event flags sets on a match or capture and stays set until software clears it.
// R5 - A set module flag whose interrupt is enabled requests the shared interrupt.
// R6 - With the idle suspend bit at 1 the counter halts while the CPU idles, at 0 it runs on.
// R7 - The watchdog enable bit makes module 5 the watchdog, clearing it disables it, and it resets to 1.
// R8 - Once the lock bit is set the watchdog cannot be disabled until the next reset.
// R9 - The three-bit timebase select picks one of eight tick sources.
// R10 - In external input mode falling edges of the count pin are counted, no faster than a quarter of the clock.
// R11 - External clock mode divides the oscillator by eight and synchronises it before use.
// R12 - While the watchdog is enabled, writes to mode bits other than the enable and lock bits are ignored.
// R13 - Mode bit 4 always reads zero and ignores writes.
// R14 - While the watchdog is enabled the counter runs whatever the run bit says.
// R15 - With the watchdog enabled, writing 1 to the module 5 flag forces a watchdog reset.
// R16 - The counter steps by one per tick while running and holds while stopped or suspended.
module counter_array_control_mode (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_write,
    input  wire logic        sfr_read,
    output logic      [7:0]  sfr_rdata,
    input  wire logic        cpu_idle,
    input  wire logic        timer0_overflow,
    input  wire logic        timer4_overflow,
    input  wire logic        timer5_overflow,
    input  wire logic        external_count_input,
    input  wire logic        ext_osc,
    input  wire logic [5:0]  module_event,
    input  wire logic [5:0]  module_irq_enable,
    output logic             counter_array_irq,
    output logic             watchdog_reset,
    output logic      [15:0] counter_value,
    output logic             counter_tick,
    output logic             watchdog_active
);

    logic [7:0]  control_reg;
    logic [7:0]  mode_reg;
    logic [15:0] count_reg;
    logic [3:0]  prescale_reg;
    logic [2:0]  eci_sync_reg;
    logic [2:0]  ext_sync_reg;
    logic        ext_div;
    logic        tick;
    logic        running;
    logic        write_control;
    logic        write_mode;
    logic        wd_enable;
    logic        wd_lock;
    counter_array_pkg::timebase_t timebase;

    assign write_control = sfr_write && (sfr_addr == `CA_CONTROL_ADDR);
    assign write_mode    = sfr_write && (sfr_addr == `CA_MODE_ADDR);
    assign wd_enable     = mode_reg[`CA_MD_WDE_BIT];
    assign wd_lock       = mode_reg[`CA_MD_LOCK_BIT];
    assign timebase      = counter_array_pkg::timebase_t'(
                               mode_reg[`CA_MD_TB_HI:`CA_MD_TB_LO]);

    // Counter runs when enabled by software or forced by the watchdog,
    // unless idle suspension applies.
    assign running = (control_reg[`CA_CTL_RUN_BIT] || wd_enable) && // R3 R14
                     !(mode_reg[`CA_MD_IDLE_BIT] && cpu_idle);      // R6

    ext_clock_divider u_ext_div (
        .ext_osc (ext_osc),
        .reset_n (reset_n),
        .div_out (ext_div)
    );

    // Third stage of each chain is only an edge history for the detector.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            eci_sync_reg <= 3'h7;
            ext_sync_reg <= 3'h0;
        end else begin
            eci_sync_reg <= {eci_sync_reg[1:0], external_count_input};
            ext_sync_reg <= {ext_sync_reg[1:0], ext_div}; // R11
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prescale_reg <= 4'h0;
        end else if (prescale_reg == `CA_DIV12_LAST) begin
            prescale_reg <= 4'h0;
        end else begin
            prescale_reg <= prescale_reg + 4'h1;
        end
    end

    // The divide-by-8 edge is taken on the rising side of the
    // synchronised wave, once per eight oscillator cycles.
    always_comb begin
        case (timebase) // R9
            counter_array_pkg::TB_SYS_DIV12:
                tick = (prescale_reg == `CA_DIV12_LAST);
            counter_array_pkg::TB_SYS_DIV4:
                tick = (prescale_reg[1:0] == `CA_DIV4_LAST);
            counter_array_pkg::TB_TIMER0:
                tick = timer0_overflow;
            counter_array_pkg::TB_EXT_FALL:
                tick = eci_sync_reg[2] && !eci_sync_reg[1]; // R10
            counter_array_pkg::TB_SYS:
                tick = 1'b1;
            counter_array_pkg::TB_EXT_DIV8:
                tick = ext_sync_reg[1] && !ext_sync_reg[2]; // R11
            counter_array_pkg::TB_TIMER4:
                tick = timer4_overflow;
            counter_array_pkg::TB_TIMER5:
                tick = timer5_overflow;
            default:
                tick = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= 16'h0000;
        end else if (running && tick) begin
            count_reg <= count_reg + 16'h0001; // R16
        end
    end

    // Control register: hardware sets beat software clears in the same cycle.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            control_reg <= `CA_CONTROL_RESET;
        end else begin
            if (write_control) begin
                control_reg <= sfr_wdata;
            end
            if (running && tick && count_reg == 16'hFFFF) begin
                control_reg[`CA_CTL_OVF_BIT] <= 1'b1; // R1
            end
            control_reg[5:0] <= (write_control ? sfr_wdata[5:0]
                                               : control_reg[5:0])
                                | module_event; // R4
        end
    end

    // Mode register: only the enable and lock may move while the
    // watchdog runs; the lock itself sticks until reset.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_reg <= `CA_MODE_RESET; // R7
        end else if (write_mode) begin
            if (!wd_enable) begin
                mode_reg <= sfr_wdata; // R12
            end
            mode_reg[`CA_MD_UNUSED_BIT] <= 1'b0; // R13
            mode_reg[`CA_MD_LOCK_BIT] <= wd_lock ||
                                         sfr_wdata[`CA_MD_LOCK_BIT]; // R8
            mode_reg[`CA_MD_WDE_BIT] <= wd_lock ||
                                        sfr_wdata[`CA_MD_WDE_BIT] ||
                                        sfr_wdata[`CA_MD_LOCK_BIT]; // R7 R8
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            counter_array_irq <= 1'b0;
            watchdog_reset    <= 1'b0;
            counter_value     <= 16'h0000;
            counter_tick      <= 1'b0;
            watchdog_active   <= 1'b0;
        end else begin
            counter_array_irq <= (control_reg[`CA_CTL_OVF_BIT] &&
                                  mode_reg[`CA_MD_OVF_IE_BIT]) || // R2
                                 |(control_reg[5:0] &
                                   module_irq_enable); // R5
            watchdog_reset    <= write_control && wd_enable &&
                                 sfr_wdata[`CA_CTL_WD_EVT_BIT]; // R15
            counter_value     <= count_reg;
            counter_tick      <= running && tick;
            watchdog_active   <= wd_enable; // R7
        end
    end

    // Reads of the run bit show the software value only, as the watchdog
    // forcing is not visible there.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_read) begin
            case (sfr_addr)
                `CA_CONTROL_ADDR: sfr_rdata <= control_reg;
                `CA_MODE_ADDR:    sfr_rdata <= mode_reg & 8'hEF; // R13
                default:          sfr_rdata <= 8'h00;
            endcase
        end
    end

endmodule : counter_array_control_mode

// ==== rtl/counter_array_defines.svh ====
`ifndef COUNTER_ARRAY_DEFINES_SVH
`define COUNTER_ARRAY_DEFINES_SVH

`define CA_CONTROL_ADDR     8'hD8
`define CA_MODE_ADDR        8'hD9

`define CA_CTL_OVF_BIT      7
`define CA_CTL_RUN_BIT      6
`define CA_CTL_WD_EVT_BIT   5

`define CA_MD_IDLE_BIT      7
`define CA_MD_WDE_BIT       6
`define CA_MD_LOCK_BIT      5
`define CA_MD_UNUSED_BIT    4
`define CA_MD_TB_HI         3
`define CA_MD_TB_LO         1
`define CA_MD_OVF_IE_BIT    0

`define CA_CONTROL_RESET    8'h00
`define CA_MODE_RESET       8'h40

`define CA_DIV12_LAST       4'hB
`define CA_DIV4_LAST        4'h3
`define CA_EXT_DIV          8

`endif

// ==== rtl/counter_array_pkg.sv ====
package counter_array_pkg;

    typedef enum logic [2:0] {
        TB_SYS_DIV12 = 3'h0,
        TB_SYS_DIV4  = 3'h1,
        TB_TIMER0    = 3'h2,
        TB_EXT_FALL  = 3'h3,
        TB_SYS       = 3'h4,
        TB_EXT_DIV8  = 3'h5,
        TB_TIMER4    = 3'h6,
        TB_TIMER5    = 3'h7
    } timebase_t;

endpackage : counter_array_pkg

// ==== rtl/ext_clock_divider.sv ====
`timescale 1ns/1ps
`include "counter_array_defines.svh"

// Divides the external oscillator by eight on its own edges; the
// resulting square wave is synchronised by the caller.
module ext_clock_divider (
    input  wire logic ext_osc,
    input  wire logic reset_n,
    output logic      div_out
);

    logic [1:0] phase_reg;

    always_ff @(posedge ext_osc or negedge reset_n) begin
        if (!reset_n) begin
            phase_reg <= 2'h0;
            div_out   <= 1'b0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == 2'h3) begin
                div_out <= ~div_out;
            end
        end
    end

endmodule : ext_clock_divider
